// File: logic/lidar_acc_pkg.sv
package lidar_acc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W        = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_PULSES    = 8'h08;
	localparam logic [7:0]  OFS_PERIOD    = 8'h0C;
	localparam logic [7:0]  OFS_PRETRIG   = 8'h10;
	localparam logic [7:0]  OFS_LASER_DAC = 8'h14;
	localparam logic [7:0]  OFS_COMP_DAC  = 8'h18;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h1C;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h20;
	localparam logic [7:0]  OFS_PROF_ADDR = 8'h24;
	localparam logic [7:0]  OFS_PROF_DATA = 8'h28;
	localparam logic [7:0]  OFS_DONE_CNT  = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_START_BIT  = 0;
	localparam int unsigned CTRL_SIM_BIT    = 1;
	localparam int unsigned STAT_BUSY_BIT   = 0;
	localparam int unsigned STAT_SIM_BIT    = 1;
	localparam int unsigned IRQ_DONE_BIT    = 0;
	localparam int unsigned IRQ_REFUSED_BIT = 1;
	localparam int unsigned IRQ_W           = 2;
	localparam int unsigned CNT_W           = 16;
	localparam int unsigned PULSE_W         = 17;
	localparam int unsigned IDX_W           = 9;
	localparam int unsigned DAC_W           = 8;
	localparam int unsigned SAMPLE_W        = 8;
	localparam int unsigned DATA_W          = 32;

	// ----------------------------------------------------------------
	// Measurement defaults and timing
	// ----------------------------------------------------------------
	localparam int unsigned PROFILE_LEN  = 500;
	localparam int unsigned ACC_W        = 24;
	localparam real         CLK_KHZ      = 10000.0;
	localparam real         REP_RATE_KHZ = 5.57;
	localparam int unsigned CLK_NS       = 100;
	localparam int unsigned SAMPLE_NS    = 100;
	localparam int unsigned SAMPLE_CYC   = SAMPLE_NS / CLK_NS;
	localparam int unsigned PERIOD_CYC   = $rtoi(CLK_KHZ / REP_RATE_KHZ);
	localparam logic [CNT_W-1:0]   PERIOD_RST  = CNT_W'(PERIOD_CYC);
	localparam logic [PULSE_W-1:0] PULSES_RST  = 17'h10000;
	localparam logic [IDX_W-1:0]   PRETRIG_RST = 9'h010;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_CLEAR  = 2'b01,
		ST_SAMPLE = 2'b11,
		ST_WAIT   = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic             laser_trig;
		logic             led_trig;
		logic             high_gain;
		logic             narrow_bw;
		logic [DAC_W-1:0] laser_dac;
		logic [DAC_W-1:0] comp_dac;
	} front_end_t;

endpackage

// File: logic/lidar_profile_accumulator.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps

module lidar_profile_accumulator #(
	parameter int unsigned N_SAMPLES = lidar_acc_pkg::PROFILE_LEN,
	parameter int unsigned ACC_BITS  = lidar_acc_pkg::ACC_W
) (
	// Clock and reset
	input  wire logic                                     sys_clk,
	input  wire logic                                     rst_n,
	// APB slave
	input  wire lidar_acc_pkg::apb_req_t                  apb_req,
	output logic [lidar_acc_pkg::DATA_W-1:0]              prdata,
	output logic                                          pready,
	output logic                                          pslverr,
	// Flash converter
	input  wire logic [lidar_acc_pkg::SAMPLE_W-1:0]       adc_data,
	// Front end and status
	output lidar_acc_pkg::front_end_t                     front_end,
	output logic                                          busy,
	output logic                                          irq
);
	import lidar_acc_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// 65536 bytes of 255 need 24 bits; wider than a bus word cannot be read
	generate
		if (ACC_BITS < 24 || ACC_BITS > DATA_W) begin : g_bad_acc
			$error("accumulator width out of range");
		end
		if (N_SAMPLES < 2 || N_SAMPLES > (1 << IDX_W)) begin : g_bad_len
			$error("profile length out of range");
		end
		if (SAMPLE_CYC != 1) begin : g_bad_rate
			$error("sample spacing must equal one clock");
		end
	endgenerate

	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_SAMPLES - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_t                           st;
		logic [CNT_W-1:0]                     cnt;
		logic [IDX_W-1:0]                     idx;
		logic [PULSE_W-1:0]                   done_cnt;
		logic                                 sim;
		logic [PULSE_W-1:0]                   pulses;
		logic [CNT_W-1:0]                     period;
		logic [IDX_W-1:0]                     pretrig;
		logic [DAC_W-1:0]                     laser_dac;
		logic [DAC_W-1:0]                     comp_dac;
		logic [IRQ_W-1:0]                     irq_stat;
		logic [IRQ_W-1:0]                     irq_mask;
		logic [IDX_W-1:0]                     prof_addr;
		logic [DATA_W-1:0]                    rdata;
		logic                                 slverr;
		logic [SAMPLE_W-1:0]                  adc_s1;
		logic [SAMPLE_W-1:0]                  adc_s2;
		logic [SAMPLE_W-1:0]                  adc_s3;
		logic [SAMPLE_W-1:0]                  adc_val;
		logic                                 laser_trig;
		logic                                 led_trig;
		logic [N_SAMPLES-1:0][ACC_BITS-1:0]   mem;
	} state_t;

	state_t q;
	state_t d;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic is_running(input seq_state_t s);
		is_running = (s != ST_IDLE);
	endfunction

	function automatic logic in_access(input apb_req_t r);
		in_access = r.psel & r.penable;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_CTRL, OFS_STATUS, OFS_PULSES, OFS_PERIOD,
			OFS_PRETRIG, OFS_LASER_DAC, OFS_COMP_DAC, OFS_IRQ_STAT,
			OFS_IRQ_MASK, OFS_PROF_ADDR, OFS_PROF_DATA,
			OFS_DONE_CNT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [DATA_W-1:0] zext_acc(
		input logic [ACC_BITS-1:0] v
	);
		zext_acc = DATA_W'(v);
	endfunction

	function automatic logic [DATA_W-1:0] reg_read(
		input state_t             s,
		input logic [ADDR_W-1:0]  a
	);
		reg_read = '0;
		case (a)
			OFS_CTRL: reg_read[CTRL_SIM_BIT] = s.sim;
			OFS_STATUS: begin
				reg_read[STAT_BUSY_BIT] = is_running(s.st);
				reg_read[STAT_SIM_BIT]  = s.sim;
			end
			OFS_PULSES:    reg_read = DATA_W'(s.pulses);
			OFS_PERIOD:    reg_read = DATA_W'(s.period);
			OFS_PRETRIG:   reg_read = DATA_W'(s.pretrig);
			OFS_LASER_DAC: reg_read = DATA_W'(s.laser_dac);
			OFS_COMP_DAC:  reg_read = DATA_W'(s.comp_dac);
			OFS_IRQ_STAT:  reg_read = DATA_W'(s.irq_stat);
			OFS_IRQ_MASK:  reg_read = DATA_W'(s.irq_mask);
			OFS_PROF_ADDR: reg_read = DATA_W'(s.prof_addr);
			OFS_PROF_DATA: reg_read = zext_acc(s.mem[s.prof_addr]);
			OFS_DONE_CNT:  reg_read = DATA_W'(s.done_cnt);
			default:       reg_read = '0;
		endcase
	endfunction

	function automatic logic [IDX_W-1:0] step_idx(
		input logic [IDX_W-1:0] a
	);
		step_idx = a + 1'b1;
	endfunction

	function automatic logic [IDX_W-1:0] next_addr(
		input logic [IDX_W-1:0] a
	);
		next_addr = (a == LAST_IDX) ? '0 : step_idx(a);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic                 setup;
		logic                 wr;
		logic                 rd;
		logic                 start;
		logic [IRQ_W-1:0]     irq_set;
		logic [IRQ_W-1:0]     irq_clr;
		logic [PULSE_W-1:0]   pulses_next;
		setup       = 1'b0;
		wr          = 1'b0;
		rd          = 1'b0;
		start       = 1'b0;
		irq_set     = '0;
		irq_clr     = '0;
		pulses_next = '0;
		d = q;

		// Three stages; a value is taken once the last two agree
		d.adc_s1 = adc_data;
		d.adc_s2 = q.adc_s1;
		d.adc_s3 = q.adc_s2;
		if (q.adc_s2 == q.adc_s3) begin
			d.adc_val = q.adc_s3;
		end
		d.laser_trig = 1'b0;
		d.led_trig   = 1'b0;

		// Bus: read data and error are prepared in the setup cycle
		setup = apb_req.psel & ~apb_req.penable;
		if (setup) begin
			d.rdata  = reg_read(q, apb_req.paddr);
			d.slverr = ~is_mapped(apb_req.paddr);
		end
		wr = in_access(apb_req) & apb_req.pwrite & ~q.slverr;
		rd = in_access(apb_req) & ~apb_req.pwrite & ~q.slverr;

		if (wr) begin
			case (apb_req.paddr)
				OFS_CTRL: begin
					start = apb_req.pwdata[CTRL_START_BIT];
					// Mode may not change under a running measurement
					if (q.st == ST_IDLE) begin
						d.sim = apb_req.pwdata[CTRL_SIM_BIT];
					end
				end
				OFS_PULSES: begin
					d.pulses = apb_req.pwdata[PULSE_W-1:0];
				end
				OFS_PERIOD: begin
					d.period = apb_req.pwdata[CNT_W-1:0];
				end
				OFS_PRETRIG: begin
					d.pretrig = apb_req.pwdata[IDX_W-1:0];
				end
				OFS_LASER_DAC: begin
					d.laser_dac = apb_req.pwdata[DAC_W-1:0];
				end
				OFS_COMP_DAC: begin
					d.comp_dac = apb_req.pwdata[DAC_W-1:0];
				end
				OFS_IRQ_STAT: begin
					irq_clr = apb_req.pwdata[IRQ_W-1:0];
				end
				OFS_IRQ_MASK: begin
					d.irq_mask = apb_req.pwdata[IRQ_W-1:0];
				end
				OFS_PROF_ADDR: begin
					if (apb_req.pwdata[IDX_W-1:0] <= LAST_IDX) begin
						d.prof_addr = apb_req.pwdata[IDX_W-1:0];
					end else begin
						d.prof_addr = '0;
					end
				end
				default: begin
				end
			endcase
		end

		// Streaming readout: each data read steps to the next location
		if (rd && apb_req.paddr == OFS_PROF_DATA) begin
			d.prof_addr = next_addr(q.prof_addr);
		end

		// Sequencer
		pulses_next = q.done_cnt + 1'b1;
		case (q.st)
			ST_IDLE: begin
				if (start) begin
					if (q.pulses != '0) begin
						d.st  = ST_CLEAR;
						d.idx = '0;
					end else begin
						irq_set[IRQ_REFUSED_BIT] = 1'b1;
					end
				end
			end
			ST_CLEAR: begin
				// One location per clock; costs N_SAMPLES cycles per run
				d.mem[q.idx] = '0;
				if (q.idx == LAST_IDX) begin
					d.st       = ST_SAMPLE;
					d.idx      = '0;
					d.cnt      = '0;
					d.done_cnt = '0;
				end else begin
					d.idx = step_idx(q.idx);
				end
				if (start) begin
					irq_set[IRQ_REFUSED_BIT] = 1'b1;
				end
			end
			ST_SAMPLE: begin
				d.mem[q.idx] = q.mem[q.idx]
					+ ACC_BITS'(q.adc_val);
				// Locations before the trigger index hold pre-launch data
				if (q.idx == q.pretrig) begin
					d.laser_trig = ~q.sim;
					d.led_trig   = q.sim;
				end
				d.cnt = q.cnt + 1'b1;
				if (q.idx == LAST_IDX) begin
					d.st = ST_WAIT;
				end else begin
					d.idx = step_idx(q.idx);
				end
				if (start) begin
					irq_set[IRQ_REFUSED_BIT] = 1'b1;
				end
			end
			ST_WAIT: begin
				// A nonzero period shorter than the profile length plus one stretches to that length
				d.cnt = q.cnt + 1'b1;
				if (q.cnt >= q.period - 1'b1) begin
					d.done_cnt = pulses_next;
					d.idx      = '0;
					d.cnt      = '0;
					if (pulses_next == q.pulses) begin
						d.st = ST_IDLE;
						irq_set[IRQ_DONE_BIT] = 1'b1;
					end else begin
						d.st = ST_SAMPLE;
					end
				end
				if (start) begin
					irq_set[IRQ_REFUSED_BIT] = 1'b1;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// A new event outweighs a clear in the same cycle
		d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;

		if (!rst_n) begin
			d         = '0;
			d.st      = ST_IDLE;
			d.pulses  = PULSES_RST;
			d.period  = PERIOD_RST;
			d.pretrig = PRETRIG_RST;
		end
	end

	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata  = q.rdata;
	// Zero wait states: read data was fetched in the setup cycle
	assign pready  = in_access(apb_req);
	assign pslverr = in_access(apb_req) & q.slverr;
	assign busy    = is_running(q.st);
	assign irq     = |(q.irq_stat & q.irq_mask);

	always_comb begin
		front_end.laser_trig = q.laser_trig;
		front_end.led_trig   = q.led_trig;
		front_end.high_gain  = is_running(q.st) & ~q.sim;
		front_end.narrow_bw  = is_running(q.st) & ~q.sim;
		front_end.laser_dac  = q.laser_dac;
		front_end.comp_dac   = q.comp_dac;
	end

endmodule

// File: sim/flash_adc_model.sv
`timescale 1ns/100ps
// Converter output moves only on the rising edge, like a clocked flash part
module flash_adc_model (
	// Clock
	input wire logic        sys_clk,
	// Analog level and byte
	input wire logic [7:0]  level,
	output logic     [7:0]  adc_data
);
	initial adc_data = 8'h00;
	always @(posedge sys_clk) begin
		adc_data <= level;
	end
endmodule

// File: sim/lidar_acc_chk.sv
`timescale 1ns/100ps
module lidar_acc_chk
	import lidar_acc_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// Watched ports
	input wire apb_req_t   apb_req,
	input wire logic       pready,
	input wire front_end_t front_end,
	input wire logic       busy
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_ready_zero_wait: assert property (
		apb_req.psel && apb_req.penable |-> pready)
		else $error("access phase without ready");
	a_start_cause: assert property ($rose(busy) |->
		$past(apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == OFS_CTRL && apb_req.pwdata[0])
		|| $past(apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == OFS_CTRL && apb_req.pwdata[0], 2))
		else $error("busy without start write");
	a_trig_busy: assert property (front_end.laser_trig |-> busy)
		else $error("trigger while idle");
	a_trig_pulse: assert property (
		front_end.laser_trig |=> !front_end.laser_trig)
		else $error("trigger longer than one cycle");
	// Pulse period is never below the profile length plus one
	a_trig_gap: assert property (
		front_end.laser_trig |=> !front_end.laser_trig [*8])
		else $error("triggers too close");
	a_clear_first: assert property ($rose(busy) |->
		(!front_end.laser_trig && !front_end.led_trig) [*8])
		else $error("trigger during clear");
	a_led_sim: assert property (
		front_end.led_trig |-> busy && !front_end.high_gain)
		else $error("led pulse outside simulated run");
	a_one_source: assert property (
		!(front_end.laser_trig && front_end.led_trig))
		else $error("laser and led together");
	a_gain_bw: assert property (
		front_end.high_gain == front_end.narrow_bw)
		else $error("gain and bandwidth differ");
	a_gain_trig: assert property (
		front_end.laser_trig |-> front_end.high_gain && front_end.narrow_bw)
		else $error("laser fired without high gain");
	a_gain_busy: assert property (front_end.high_gain |-> busy)
		else $error("high gain while idle");
endmodule
bind lidar_profile_accumulator lidar_acc_chk chk (
	.sys_clk  (sys_clk),
	.rst_n    (rst_n),
	.apb_req  (apb_req),
	.pready   (pready),
	.front_end(front_end),
	.busy     (busy)
);

// File: sim/lidar_profile_accumulator_tb_top.sv
`timescale 1ns/100ps
module lidar_profile_accumulator_tb_top;
	import lidar_acc_pkg::*;
	// ----------------------------------------------------------------
	// Bench
	// ----------------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	apb_req_t    apb_req = '0;
	logic [31:0] prdata, rv;
	logic        pready, pslverr, busy, irq, rerr;
	logic [7:0]  adc_data;
	logic [7:0]  level = 8'h07;
	front_end_t  front_end;
	int          n_errors = 0;
	int          total_checks = 0;
	integer      nl, nled, ng;
	always #50 sys_clk = ~sys_clk;
	lidar_profile_accumulator #(.N_SAMPLES(16), .ACC_BITS(24)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_data(adc_data), .front_end(front_end), .busy(busy), .irq(irq));
	flash_adc_model adc (.sys_clk(sys_clk), .level(level), .adc_data(adc_data));
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			n_errors++;
			wrap_up;
		end
		rv = prdata;
		rerr = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	// Counts trigger and gain activity until the run ends
	task run;
		int i;
		nl = 0; nled = 0; ng = 0;
		for (i = 0; i < 3000; i++) begin
			@(negedge sys_clk);
			nl += front_end.laser_trig;
			nled += front_end.led_trig;
			ng += front_end.high_gain;
			if (i > 2 && busy === 1'b0) break;
		end
		if (i == 3000) begin
			n_errors++;
			wrap_up;
		end
	endtask
	task prof(input logic [31:0] e);
		int i;
		xfer(1'b1, OFS_PROF_ADDR, 32'h0);
		for (i = 0; i < 16; i++) begin
			xfer(1'b0, OFS_PROF_DATA, 32'h0);
			chk(rv, e);
		end
		xfer(1'b0, OFS_PROF_ADDR, 32'h0); chk(rv, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		xfer(1'b0, OFS_PULSES, 32'h0); chk(rv, 32'h10000);
		xfer(1'b0, OFS_PERIOD, 32'h0); chk(rv, 32'h703);
		xfer(1'b0, OFS_PRETRIG, 32'h0); chk(rv, 32'h10);
		xfer(1'b0, 8'h40, 32'h0); chk({rv[30:0], rerr}, 32'h1);
		xfer(1'b1, OFS_LASER_DAC, 32'hA5);
		xfer(1'b1, OFS_COMP_DAC, 32'h3C);
		@(negedge sys_clk);
		chk(front_end.laser_dac, 32'hA5);
		chk(front_end.comp_dac, 32'h3C);
		$display("test reset and converters done");
		xfer(1'b1, OFS_PULSES, 32'h2);
		xfer(1'b1, OFS_PERIOD, 32'h14);
		xfer(1'b1, OFS_PRETRIG, 32'h4);
		xfer(1'b1, OFS_IRQ_MASK, 32'h1);
		xfer(1'b1, OFS_CTRL, 32'h1);
		run;
		chk(nl, 32'h2);
		chk(ng > 0, 32'h1);
		chk(irq, 32'h1);
		xfer(1'b0, OFS_IRQ_STAT, 32'h0); chk(rv, 32'h1);
		xfer(1'b0, OFS_DONE_CNT, 32'h0); chk(rv, 32'h2);
		prof(32'hE);
		xfer(1'b1, OFS_IRQ_STAT, 32'h1);
		@(negedge sys_clk);
		chk(irq, 32'h0);
		xfer(1'b1, OFS_PULSES, 32'h0);
		xfer(1'b1, OFS_CTRL, 32'h1);
		@(negedge sys_clk);
		chk(busy, 32'h0);
		xfer(1'b0, OFS_IRQ_STAT, 32'h0); chk(rv, 32'h2);
		xfer(1'b1, OFS_IRQ_STAT, 32'h2);
		xfer(1'b1, OFS_PULSES, 32'h2);
		$display("test normal run done");
		level <= 8'h03;
		xfer(1'b1, OFS_CTRL, 32'h3);
		xfer(1'b1, OFS_CTRL, 32'h1);
		xfer(1'b0, OFS_STATUS, 32'h0); chk(rv, 32'h3);
		run;
		chk(busy, 32'h0);
		chk(nled, 32'h2);
		chk(nl + ng, 32'h0);
		xfer(1'b0, OFS_IRQ_STAT, 32'h0); chk(rv, 32'h3);
		xfer(1'b0, OFS_STATUS, 32'h0); chk(rv, 32'h2);
		xfer(1'b1, OFS_PROF_ADDR, 32'h1FF);
		xfer(1'b0, OFS_PROF_ADDR, 32'h0); chk(rv, 32'h0);
		prof(32'h6);
		xfer(1'b1, OFS_IRQ_MASK, 32'h0);
		@(negedge sys_clk);
		chk(irq, 32'h0);
		$display("test simulated run done");
		wrap_up;
	end
endmodule
